// File: verilog/pgir_defines.svh
// offsets, field positions and reset values of the power-good register bank
`ifndef PGIR_DEFINES_SVH
`define PGIR_DEFINES_SVH
`define PGIR_OFS_PG_CTRL1 8'h15
`define PGIR_OFS_PG_CTRL2 8'h16
`define PGIR_OFS_FAULT 8'h17
`define PGIR_OFS_RESET 8'h18
`define PGIR_OFS_TOP_INT 8'h19
`define PGIR_RST_PG_CTRL1 8'h73
`define PGIR_RST_PG_CTRL2 8'h04
`define PGIR_BIT_POL 7
`define PGIR_BIT_TWARN_GATE 2
`define PGIR_BIT_FAULT_SEL 1
`define PGIR_BIT_MODE 0
`define PGIR_BIT_SOFT_RESET 0
`define PGIR_BIT_DROP 7
`define PGIR_BIT_LINREG 6
`define PGIR_BIT_STEPDOWN 5
`define PGIR_BIT_CLKSYNC 4
`define PGIR_BIT_TSD 3
`define PGIR_BIT_TWARN 2
`define PGIR_BIT_OVP 1
`define PGIR_BIT_IMEAS 0
`define PGIR_FAULT_MASK 8'h0F
`define PGIR_CTRL2_MASK 8'h07
`define PGIR_LATCH_MASK 8'h9F
`define PGIR_RESET_CYCLES 4'h4
`endif

// File: verilog/pgir_pkg.sv
// types shared by the power-good register bank
package pgir_pkg;
   typedef enum logic [1:0] {PGIR_RUN, PGIR_SRST, PGIR_RELOAD} pgir_state_e;

   // register write/read request from the serial interface
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pgir_req_s;

   // live analog events and levels
   typedef struct packed {
      logic [3:0] rail_ok;
      logic twarn;
      logic tsd;
      logic ovp;
      logic ext_clk_present;
      logic imeas_done;
      logic [7:0] stepdown_events;
      logic [7:0] linreg_events;
   } pgir_evt_s;
endpackage : pgir_pkg

// File: verilog/pgir_soft_reset.sv
// software reset sequencer with self-clearing request bit
`include "pgir_defines.svh"
module pgir_soft_reset
   import pgir_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic start,
   output logic regs_clear,
   output logic reload_otp,
   output logic serial_reset,
   output logic busy
);
   typedef struct packed {
      pgir_state_e st;
      logic [3:0] cnt;
   } pgir_srst_s;

   pgir_srst_s r;
   pgir_srst_s next_r;

   // hold registers in reset, then request a memory reload
   always_comb
   begin
      next_r = r;
      case (r.st)
         PGIR_RUN:
         begin
            if (start)
            begin
               next_r.st = PGIR_SRST;
               next_r.cnt = `PGIR_RESET_CYCLES;
            end
         end
         PGIR_SRST:
         begin
            next_r.cnt = r.cnt - 4'h1;
            if (r.cnt == 4'h1)
               next_r.st = PGIR_RELOAD;
         end
         PGIR_RELOAD:
            next_r.st = PGIR_RUN;
         default:
            next_r.st = PGIR_RUN;
      endcase
   end

   // state register
   always_ff @(posedge mclk)
   begin
      if (!resetn)
         r <= '{st: PGIR_RUN, cnt: 4'h0};
      else
         r <= next_r;
   end

   assign regs_clear = (r.st == PGIR_SRST);
   assign serial_reset = (r.st == PGIR_SRST);
   assign reload_otp = (r.st == PGIR_RELOAD);
   assign busy = (r.st != PGIR_RUN);
endmodule : pgir_soft_reset

// File: verilog/pgir_regs.sv
// power-good control, fault latches, soft reset and top interrupt register
// Behaviour
// - thermal warning forces indicator inactive when gated
// - select live status or latched faults
// - mode bit: 0 gated, 1 continuous
// - four fault latches set on drop of a rail whose monitor enable bit is set
// - fault cleared by write one, rail valid
// - soft reset restores defaults, reloads, resets serial
// - soft reset bit clears itself
// - bit 7 latches indicator falling to inactive
// - bit 6 summarises linear regulator events
// - bit 5 summarises step-down events
// - bit 4 latches external clock change
// - bit 3 thermal shutdown, disable rails, outputs low
// - refuse enables while shutdown latch set
// - bit 2 latches thermal warning
// - bit 1 overvoltage, disable rails, outputs low
// - bit 0 latches load current result
// - latched bits clear by writing one
// - per-rail monitor enable bits
// - polarity bit selects indicator level
`include "pgir_defines.svh"
module pgir_regs
   import pgir_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire pgir_req_s req,
   input wire pgir_evt_s evt,
   input wire logic [3:0] rail_enable_req,
   input wire logic ok_indicator_active,
   output logic [7:0] rdata,
   output logic power_ok_indicator,
   output logic [3:0] rail_enable,
   output logic outputs_force_low,
   output logic ok_indicator_mode,
   output logic reload_otp,
   output logic serial_reset
);
   typedef struct packed {
      logic [7:0] pg_ctrl1;
      logic [7:0] pg_ctrl2;
      logic [3:0] fault;
      logic [7:0] top_int;
      logic ok_q;
      logic clk_q;
      logic imeas_q;
      logic twarn_q;
      logic tsd_q;
      logic ovp_q;
      logic [7:0] rdata;
      logic soft_req;
      logic ok_pin;
   } pgir_regs_s;

   pgir_regs_s r;
   pgir_regs_s next_r;
   logic regs_clear;
   logic busy;
   logic live_ok;
   logic ok_level;
   logic [3:0] monitored_bad;

   // write-one-to-clear with set winning over the clear
   function automatic logic [7:0] w1c(input logic [7:0] cur,
                                      input logic [7:0] set,
                                      input logic [7:0] clr);
      w1c = (cur & ~clr) | set;
   endfunction : w1c

   function automatic logic hit(input pgir_req_s q, input logic [7:0] a);
      hit = q.wr && (q.addr == a);
   endfunction : hit

   pgir_soft_reset u_srst (
      .mclk(mclk),
      .resetn(resetn),
      .start(r.soft_req),
      .regs_clear(regs_clear),
      .reload_otp(reload_otp),
      .serial_reset(serial_reset),
      .busy(busy)
   );

   // monitored rails that are not valid
   assign monitored_bad = r.pg_ctrl1[3:0] & ~evt.rail_ok;

   // indicator decision: live or latched source, thermal gating
   always_comb
   begin
      if (r.pg_ctrl2[`PGIR_BIT_FAULT_SEL])
         live_ok = ~|r.fault;
      else
         live_ok = ~|monitored_bad;
      if (r.pg_ctrl2[`PGIR_BIT_TWARN_GATE] && evt.twarn)
         live_ok = 1'b0;
   end

   assign ok_level = live_ok ^ r.pg_ctrl1[`PGIR_BIT_POL];
   assign ok_indicator_mode = r.pg_ctrl2[`PGIR_BIT_MODE];

   // next-state of the whole register bank
   always_comb
   begin
      logic [7:0] set_top;
      logic [7:0] clr_top;
      logic [3:0] clr_fault;
      logic [7:0] wd;
      logic [7:0] fault_w;
      set_top = 8'h00;
      fault_w = 8'h00;
      clr_top = 8'h00;
      clr_fault = 4'h0;
      wd = req.wdata;
      next_r = r;
      next_r.ok_q = ok_indicator_active;
      next_r.clk_q = evt.ext_clk_present;
      next_r.imeas_q = evt.imeas_done;
      next_r.twarn_q = evt.twarn;
      next_r.tsd_q = evt.tsd;
      next_r.ovp_q = evt.ovp;
      next_r.soft_req = 1'b0;
      next_r.ok_pin = ok_level;
      // event detection
      set_top[`PGIR_BIT_DROP] = r.ok_q && !ok_indicator_active;
      set_top[`PGIR_BIT_CLKSYNC] = r.clk_q ^ evt.ext_clk_present;
      set_top[`PGIR_BIT_TSD] = evt.tsd && !r.tsd_q;
      set_top[`PGIR_BIT_TWARN] = evt.twarn && !r.twarn_q;
      set_top[`PGIR_BIT_OVP] = evt.ovp && !r.ovp_q;
      set_top[`PGIR_BIT_IMEAS] = evt.imeas_done && !r.imeas_q;
      // host writes
      if (hit(req, `PGIR_OFS_PG_CTRL1))
         next_r.pg_ctrl1 = wd;
      if (hit(req, `PGIR_OFS_PG_CTRL2))
         next_r.pg_ctrl2 = wd & `PGIR_CTRL2_MASK;
      if (hit(req, `PGIR_OFS_FAULT))
         clr_fault = wd[3:0] & evt.rail_ok;
      if (hit(req, `PGIR_OFS_TOP_INT))
         clr_top = wd & `PGIR_LATCH_MASK;
      if (hit(req, `PGIR_OFS_RESET) && wd[`PGIR_BIT_SOFT_RESET] && !busy)
         next_r.soft_req = 1'b1;
      fault_w = w1c({4'h0, r.fault}, {4'h0, monitored_bad},
                    {4'h0, clr_fault});
      next_r.fault = fault_w[3:0];
      next_r.top_int = w1c(r.top_int & `PGIR_LATCH_MASK, set_top,
                           clr_top);
      next_r.top_int[`PGIR_BIT_LINREG] = |evt.linreg_events;
      next_r.top_int[`PGIR_BIT_STEPDOWN] = |evt.stepdown_events;
      // read data
      case (req.addr)
         `PGIR_OFS_PG_CTRL1: next_r.rdata = r.pg_ctrl1;
         `PGIR_OFS_PG_CTRL2: next_r.rdata = r.pg_ctrl2;
         `PGIR_OFS_FAULT: next_r.rdata = {4'h0, r.fault};
         `PGIR_OFS_RESET: next_r.rdata = {7'h00, r.soft_req | busy};
         `PGIR_OFS_TOP_INT: next_r.rdata = r.top_int;
         default: next_r.rdata = 8'h00;
      endcase
      if (!req.rd)
         next_r.rdata = r.rdata;
      // soft reset returns the host registers and read data to defaults
      if (regs_clear)
      begin
         next_r.pg_ctrl1 = `PGIR_RST_PG_CTRL1;
         next_r.pg_ctrl2 = `PGIR_RST_PG_CTRL2;
         next_r.fault = 4'h0;
         next_r.top_int = 8'h00;
         next_r.rdata = 8'h00;
      end
   end

   // register the state
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         r <= '0;
         r.pg_ctrl1 <= `PGIR_RST_PG_CTRL1;
         r.pg_ctrl2 <= `PGIR_RST_PG_CTRL2;
      end
      else
         r <= next_r;
   end

   // protection: rails off and outputs low on shutdown or overvoltage
   assign outputs_force_low = r.top_int[`PGIR_BIT_TSD] |
                              r.top_int[`PGIR_BIT_OVP] |
                              evt.tsd | evt.ovp;
   assign rail_enable = outputs_force_low ? 4'h0 : rail_enable_req;
   assign rdata = r.rdata;

   // pin level from the state flops; inactive after reset, no false drop
   assign power_ok_indicator = r.ok_pin;

   property p_drop;
      @(posedge mclk) disable iff (!resetn)
      (r.ok_q && !ok_indicator_active && !regs_clear)
      |=> r.top_int[`PGIR_BIT_DROP];
   endproperty
   a_drop: assert property (p_drop) else $error("drop not latched");

   property p_twarn_gate;
      @(posedge mclk) disable iff (!resetn)
      (r.pg_ctrl2[`PGIR_BIT_TWARN_GATE] && evt.twarn)
      |=> power_ok_indicator == $past(r.pg_ctrl1[`PGIR_BIT_POL]);
   endproperty
   a_twarn_gate: assert property (p_twarn_gate)
      else $error("warning did not gate");

   property p_latched_src;
      @(posedge mclk) disable iff (!resetn)
      (r.pg_ctrl2[`PGIR_BIT_FAULT_SEL] && |r.fault)
      |=> !power_ok_indicator ^ $past(r.pg_ctrl1[`PGIR_BIT_POL]);
   endproperty
   a_latched_src: assert property (p_latched_src)
      else $error("latched fault ignored");

   property p_fault_set;
      @(posedge mclk) disable iff (!resetn)
      (monitored_bad[0] && !regs_clear) |=> r.fault[0];
   endproperty
   a_fault_set: assert property (p_fault_set)
      else $error("fault latch not set");

   property p_fault_hold;
      @(posedge mclk) disable iff (!resetn)
      (r.fault[1] && !evt.rail_ok[1] && !regs_clear) |=> r.fault[1];
   endproperty
   a_fault_hold: assert property (p_fault_hold)
      else $error("fault cleared while rail bad");

   property p_soft;
      @(posedge mclk) disable iff (!resetn)
      r.soft_req |=> regs_clear ##4 !regs_clear ##[1:3] !busy;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset seq");

   property p_summary;
      @(posedge mclk) disable iff (!resetn)
      (!regs_clear) |=> r.top_int[`PGIR_BIT_LINREG] ==
                        $past(|evt.linreg_events);
   endproperty
   a_summary: assert property (p_summary)
      else $error("summary mismatch");

   property p_protect;
      @(posedge mclk) disable iff (!resetn)
      r.top_int[`PGIR_BIT_TSD] |-> rail_enable == 4'h0;
   endproperty
   a_protect: assert property (p_protect)
      else $error("rail enabled in shutdown");

   property p_mode_wr;
      @(posedge mclk) disable iff (!resetn)
      (req.wr && req.addr == `PGIR_OFS_PG_CTRL2 && !regs_clear)
      |=> ok_indicator_mode == $past(req.wdata[`PGIR_BIT_MODE]);
   endproperty
   a_mode_wr: assert property (p_mode_wr)
      else $error("mode bit not taken");

   property p_fault_clr;
      @(posedge mclk) disable iff (!resetn)
      (req.wr && req.addr == `PGIR_OFS_FAULT && req.wdata[0] &&
       evt.rail_ok[0] && !regs_clear) |=> !r.fault[0];
   endproperty
   a_fault_clr: assert property (p_fault_clr)
      else $error("valid rail fault not cleared");

   property p_rd_idle;
      @(posedge mclk) disable iff (!resetn)
      (req.rd && req.addr == `PGIR_OFS_RESET && !busy && !r.soft_req)
      |=> rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("soft reset bit did not clear");

   property p_summary_sd;
      @(posedge mclk) disable iff (!resetn)
      (!regs_clear) |=> r.top_int[`PGIR_BIT_STEPDOWN] ==
                        $past(|evt.stepdown_events);
   endproperty
   a_summary_sd: assert property (p_summary_sd)
      else $error("step-down summary mismatch");

   property p_clksync;
      @(posedge mclk) disable iff (!resetn)
      (evt.ext_clk_present != r.clk_q && !regs_clear)
      |=> r.top_int[`PGIR_BIT_CLKSYNC];
   endproperty
   a_clksync: assert property (p_clksync)
      else $error("clock change not latched");

   property p_tsd;
      @(posedge mclk) disable iff (!resetn)
      (evt.tsd && !r.tsd_q && !regs_clear) |=> r.top_int[`PGIR_BIT_TSD];
   endproperty
   a_tsd: assert property (p_tsd)
      else $error("shutdown not latched");

   property p_twarn;
      @(posedge mclk) disable iff (!resetn)
      (evt.twarn && !r.twarn_q && !regs_clear)
      |=> r.top_int[`PGIR_BIT_TWARN];
   endproperty
   a_twarn: assert property (p_twarn)
      else $error("warning not latched");

   property p_ovp;
      @(posedge mclk) disable iff (!resetn)
      (evt.ovp && !r.ovp_q && !regs_clear) |=> r.top_int[`PGIR_BIT_OVP];
   endproperty
   a_ovp: assert property (p_ovp)
      else $error("overvoltage not latched");

   property p_live_off;
      @(posedge mclk) disable iff (!resetn)
      (evt.tsd || evt.ovp) |-> outputs_force_low && rail_enable == 4'h0;
   endproperty
   a_live_off: assert property (p_live_off)
      else $error("outputs not forced low");

   property p_imeas;
      @(posedge mclk) disable iff (!resetn)
      (evt.imeas_done && !r.imeas_q && !regs_clear)
      |=> r.top_int[`PGIR_BIT_IMEAS];
   endproperty
   a_imeas: assert property (p_imeas)
      else $error("measurement event not latched");

   property p_w1c;
      @(posedge mclk) disable iff (!resetn)
      (req.wr && req.addr == `PGIR_OFS_TOP_INT &&
       req.wdata[`PGIR_BIT_TSD] && !(evt.tsd && !r.tsd_q) && !regs_clear)
      |=> !r.top_int[`PGIR_BIT_TSD];
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("latched bit not cleared");

   property p_zero_wr;
      @(posedge mclk) disable iff (!resetn)
      (req.wr && req.addr == `PGIR_OFS_TOP_INT &&
       !req.wdata[`PGIR_BIT_CLKSYNC] && r.top_int[`PGIR_BIT_CLKSYNC] &&
       !regs_clear) |=> r.top_int[`PGIR_BIT_CLKSYNC];
   endproperty
   a_zero_wr: assert property (p_zero_wr)
      else $error("zero write cleared a bit");

   property p_live_pol;
      @(posedge mclk) disable iff (!resetn)
      (resetn && !r.pg_ctrl2[`PGIR_BIT_FAULT_SEL] && !(|monitored_bad) &&
       !(r.pg_ctrl2[`PGIR_BIT_TWARN_GATE] && evt.twarn))
      |=> power_ok_indicator != $past(r.pg_ctrl1[`PGIR_BIT_POL]);
   endproperty
   a_live_pol: assert property (p_live_pol)
      else $error("indicator level wrong");
endmodule : pgir_regs

// File: test/pgir_host.sv
// host model issuing one-cycle register accesses to the bank
module pgir_host
   import pgir_pkg::*;
(
   input wire logic mclk,
   output pgir_req_s req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   // one access, then the bus shows inverted leftovers
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
      @(posedge mclk);
      req <= '{w, ~w, a, d};
      @(posedge mclk);
      req <= '{1'b0, 1'b0, ~a, ~d};
   endtask : acc
endmodule : pgir_host

// File: test/power_good_and_top_interrupt_regs_tb_top.sv
// self-checking bench for the power-good register bank
module power_good_and_top_interrupt_regs_tb_top
   import pgir_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   pgir_req_s req;
   pgir_evt_s ev;
   logic [3:0] ren_req;
   logic [3:0] ren;
   logic [7:0] rdata;
   logic [7:0] r;
   logic pok, flo, mode, rl, srst, rd_d;
   logic [7:0] exp_q[$];
   int n_fail = 0;
   int compares = 0;
   int n_rl = 0;
   int n_sr = 0;

   initial forever #20 mclk = ~mclk;

   pgir_host u_host (.mclk(mclk), .req(req));
   // indicator pin level is fed back as the active flag
   pgir_regs u_dut (.mclk(mclk), .resetn(resetn), .req(req), .evt(ev),
      .rail_enable_req(ren_req), .ok_indicator_active(pok),
      .rdata(rdata), .power_ok_indicator(pok), .rail_enable(ren),
      .outputs_force_low(flo), .ok_indicator_mode(mode),
      .reload_otp(rl), .serial_reset(srst));

   task automatic cmp(input logic [7:0] got, input logic [7:0] want);
      compares++;
      if (got !== want)
      begin
         n_fail++;
         $display("Error %0t: got %h want %h", $time, got, want);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_host.acc(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_host.acc(1'b0, a, 8'h00);
   endtask : rd

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick

   task automatic print_verdict();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict

   // read data lands one cycle after the request; count pulses
   always @(posedge mclk)
   begin
      if (rd_d === 1'b1 && exp_q.size() > 0)
         cmp(rdata, exp_q.pop_front());
      if (rl === 1'b1)
         n_rl++;
      if (resetn && srst === 1'b1)
         n_sr++;
      rd_d <= req.rd;
   end

   // hang guard
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      print_verdict();
   end

   // main sequence
   initial
   begin
      ev = '0;
      ev.rail_ok = 4'hF;
      ren_req = 4'hF;
      void'($urandom(32'h9dbf2c7a));
      tick(4);
      resetn <= 1'b1;
      rd(8'h15, 8'h73);
      rd(8'h16, 8'h04);
      rd(8'h17, 8'h00);
      rd(8'h18, 8'h00);
      rd(8'h3C, 8'h00);
      cmp({7'h00, pok}, 8'h01);
      ev.twarn <= 1'b1;
      tick(3);
      cmp({7'h00, pok}, 8'h00);
      ev.twarn <= 1'b0;
      ev.tsd <= 1'b1;
      ev.ovp <= 1'b1;
      ev.ext_clk_present <= 1'b1;
      ev.imeas_done <= 1'b1;
      tick(3);
      cmp({7'h00, flo}, 8'h01);
      ev.tsd <= 1'b0;
      ev.ovp <= 1'b0;
      ev.imeas_done <= 1'b0;
      tick(3);
      cmp({4'h0, ren}, 8'h00);
      rd(8'h19, 8'h9F);
      wr(8'h19, 8'h00);
      rd(8'h19, 8'h9F);
      wr(8'h19, 8'h9F);
      rd(8'h19, 8'h00);
      tick(2);
      cmp({4'h0, ren}, 8'h0F);
      r = 8'($urandom_range(255, 1));
      ev.linreg_events <= r;
      ev.stepdown_events <= ~r | 8'h01;
      tick(3);
      wr(8'h19, 8'h60);
      rd(8'h19, 8'h60);
      ev.linreg_events <= 8'h00;
      tick(3);
      rd(8'h19, 8'h20);
      ev.stepdown_events <= 8'h00;
      tick(3);
      rd(8'h19, 8'h00);
      ev.rail_ok <= 4'hA;
      tick(3);
      rd(8'h17, 8'h01);
      wr(8'h17, 8'h01);
      rd(8'h17, 8'h01);
      ev.rail_ok <= 4'hF;
      tick(3);
      cmp({7'h00, pok}, 8'h01);
      rd(8'h19, 8'h80);
      wr(8'h16, 8'h06);
      tick(2);
      cmp({7'h00, pok}, 8'h00);
      wr(8'h17, 8'h01);
      rd(8'h17, 8'h00);
      r = 8'($urandom) & 8'h07;
      wr(8'h16, r);
      rd(8'h16, r);
      cmp(mode, {7'h00, r[0]});
      wr(8'h18, 8'h01);
      tick(10);
      rd(8'h18, 8'h00);
      rd(8'h16, 8'h04);
      rd(8'h15, 8'h73);
      tick(2);
      cmp(n_rl[7:0], 8'h01);
      cmp(n_sr[7:0], 8'h04);
      cmp(8'(exp_q.size()), 8'h00);
      print_verdict();
   end
endmodule : power_good_and_top_interrupt_regs_tb_top
